/* logic/rpc_pkg.sv */
// constants and types for the reset pin control block
package rpc_pkg;
   // power-on reset timer interval, in microseconds (plain default)
   localparam int unsigned PorTimeUs = 1000;
   localparam int unsigned ClockMhz = 40;
   localparam int unsigned PorCycles = PorTimeUs * ClockMhz;
   localparam int PorCntW = 16;
   localparam logic [PorCntW-1:0] PorCntZero = 16'h0000;
   localparam logic [1:0] SyncZero = 2'h0;
   // reset sequencer states, gray along idle -> drive -> hold
   typedef enum logic [1:0] {
      RPC_IDLE = 2'b00,
      RPC_DRIVE = 2'b01,
      RPC_HOLD = 2'b11
   } rpc_state_t;
endpackage

/* logic/rpc_sync.sv */
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module rpc_sync (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // level in and out
   input wire logic din,
   output logic dout
);
   logic stage1_q;
   logic stage1_d;
   logic stage2_q;
   logic stage2_d;

   always_comb begin
      stage1_d = din;
      stage2_d = stage1_q;
   end

   // reset value high: the pin idles high through the pull-up
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stage1_q <= 1'b1;
         stage2_q <= 1'b1;
      end else begin
         stage1_q <= stage1_d;
         stage2_q <= stage2_d;
      end
   end

   assign dout = stage2_q;
endmodule

/* logic/rpc_reset_pin_control.sv */
// reset source collector and shared reset pin driver
// How it works
// - internal reset asserts on power-on, watchdog, stop recovery, brown-out or pin low outside stop mode
// - power-on or watchdog reset pulls the pin low for the timer interval, except the cycles under brown-out; the timer does not pause
// - internal pull-up on the pin, switched off while the block drives low
// - release the pin one cycle after the brown-out condition rises, until one cycle after it falls
// - external pin low never ends stop mode; only recovery sources do
`timescale 1ns/1ps
module rpc_reset_pin_control
   import rpc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // reset causes
   input wire logic powerOnEvent,
   input wire logic watchdogTimeout,
   input wire logic stopRecovery,
   input wire logic brown_out_condition,
   // stop mode state from the core
   input wire logic stopModeActive,
   // shared reset pin, open-drain
   input wire logic resetPinIn,
   output logic resetPinOut,
   output logic resetPinOe,
   output logic pullUpEnable,
   // results
   output logic sysReset,
   output logic stopWake
);
   // sequencer state and timer
   rpc_state_t state_q;
   rpc_state_t state_d;
   logic [PorCntW-1:0] cnt_q;
   logic [PorCntW-1:0] cnt_d;

   // pin driver
   logic oe_q;
   logic oe_d;
   logic pull_q;
   logic pull_d;

   // internal reset and wake
   logic sysRst_q;
   logic sysRst_d;
   logic wake_q;
   logic wake_d;

   // synchronised pin
   logic pinSync;
   logic pinLow;

   // sequencer decode
   logic driveReq;
   logic timerDone;
   logic drivePhase;
   logic pinReset;

   ////////////////////////////////////////////////////////////////
   // pin synchroniser
   // the line is asynchronous to the clock
   rpc_sync u_rpc_sync (
      .clock(clock),
      .rst(rst),
      .din(resetPinIn),
      .dout(pinSync)
   );

   ////////////////////////////////////////////////////////////////
   // request decode
   always_comb begin
      driveReq = powerOnEvent | watchdogTimeout;
      timerDone = (cnt_q == PorCntZero);
      pinLow = ~pinSync;
   end

   ////////////////////////////////////////////////////////////////
   // sequencer next state: idle, drive for the interval, hold until the line rises
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         RPC_IDLE: begin
            // rest until a power-on or watchdog request
            if (driveReq) begin
               state_d = RPC_DRIVE;
               cnt_d = PorCntW'(PorCycles - 1);
            end
         end
         RPC_DRIVE: begin
            // count the interval down to zero
            if (driveReq) begin
               // a new request restarts the full interval
               cnt_d = PorCntW'(PorCycles - 1);
            end else if (timerDone) begin
               state_d = RPC_HOLD;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         RPC_HOLD: begin
            // wait for the line to rise before rearming
            if (driveReq) begin
               state_d = RPC_DRIVE;
               cnt_d = PorCntW'(PorCycles - 1);
            end else if (pinSync) begin
               state_d = RPC_IDLE;
            end
         end
         default: begin
            state_d = RPC_IDLE;
            cnt_d = PorCntZero;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // release acts as a request at the first edge
         state_q <= RPC_DRIVE;
         cnt_q <= PorCntW'(PorCycles);
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // pin driver next state
   always_comb begin
      drivePhase = (state_d == RPC_DRIVE);
      // outside the drive phase: released, pull-up on
      oe_d = 1'b0;
      pull_d = 1'b1;
      if (drivePhase) begin
         if (brown_out_condition) begin
            // brown-out: line left to the pull-up
            oe_d = 1'b0;
            pull_d = 1'b1;
         end else begin
            oe_d = 1'b1;
            pull_d = 1'b0;
         end
      end
   end

   // pin driver registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         oe_q <= 1'b0;
         pull_q <= 1'b1;
      end else begin
         oe_q <= oe_d;
         pull_q <= pull_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // internal reset next state
   always_comb begin
      // pin low counts only outside stop mode
      pinReset = pinLow & ~stopModeActive;
      sysRst_d = 1'b0;
      if (powerOnEvent) begin
         sysRst_d = 1'b1;
      end
      if (watchdogTimeout) begin
         sysRst_d = 1'b1;
      end
      if (drivePhase) begin
         sysRst_d = 1'b1;
      end
      if (stopRecovery) begin
         sysRst_d = 1'b1;
      end
      if (brown_out_condition) begin
         sysRst_d = 1'b1;
      end
      if (pinReset) begin
         sysRst_d = 1'b1;
      end
   end

   // internal reset register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sysRst_q <= 1'b1;
      end else begin
         sysRst_q <= sysRst_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // stop mode wake next state
   always_comb begin
      wake_d = 1'b0;
      // only a recovery source ends stop mode, never the pin
      if (stopModeActive & stopRecovery) begin
         wake_d = 1'b1;
      end
   end

   // stop mode wake register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_d;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   // open-drain pin: data held low, enable does the driving
   assign resetPinOut = 1'b0;
   assign resetPinOe = oe_q;
   assign pullUpEnable = pull_q;

   // results to the core
   assign sysReset = sysRst_q;
   assign stopWake = wake_q;
endmodule

/* verif/rpc_reset_pin_control_assertions.sv */
// port checker for the reset pin control block
`timescale 1ns/1ps
module rpc_checker (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // reset causes and stop state
   input wire logic powerOnEvent,
   input wire logic watchdogTimeout,
   input wire logic stopRecovery,
   input wire logic brown_out_condition,
   input wire logic stopModeActive,
   // reset pin
   input wire logic resetPinIn,
   input wire logic resetPinOe,
   input wire logic pullUpEnable,
   // results
   input wire logic sysReset,
   input wire logic stopWake
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   cause_reset_a: assert property ((powerOnEvent | watchdogTimeout | stopRecovery | brown_out_condition)
      |=> sysReset) else $error("no reset");
   pin_drive_a: assert property ((powerOnEvent | watchdogTimeout) && !brown_out_condition |=> resetPinOe)
      else $error("no drive");
   pull_off_a: assert property (pullUpEnable == !resetPinOe) else $error("pull-up");
   brown_quiet_a: assert property (brown_out_condition |=> !resetPinOe) else $error("brown drive");
   stop_wake_a: assert property (stopWake == $past(stopRecovery && stopModeActive)) else $error("wake");
   pin_hold_a: assert property ((!resetPinIn && !stopModeActive) [*4] |-> sysReset) else $error("pin");
endmodule
bind rpc_reset_pin_control rpc_checker u_rpc_checker (.clock(clock), .rst(rst), .powerOnEvent(powerOnEvent),
   .watchdogTimeout(watchdogTimeout), .stopRecovery(stopRecovery), .brown_out_condition(brown_out_condition),
   .stopModeActive(stopModeActive), .resetPinIn(resetPinIn), .resetPinOe(resetPinOe),
   .pullUpEnable(pullUpEnable), .sysReset(sysReset), .stopWake(stopWake));

/* verif/rpc_line_model.sv */
// shared reset line with an outside open-drain driver
`timescale 1ns/1ps
module rpc_line_model (
   // drivers on the line
   input wire logic resetPinOe,
   input wire logic pullUpEnable,
   input wire logic extLow,
   // sensed level
   output logic line
);
   assign line = !(resetPinOe | extLow) & pullUpEnable;
endmodule

/* verif/rpc_reset_pin_control_tb.sv */
// testbench for the reset pin control block
`timescale 1ns/1ps
module rpc_reset_pin_control_tb;
   import rpc_pkg::*;
   logic clock = 0, rst = 1, por = 0, wdt = 0, rec = 0, bo = 0, stp = 0, extLow = 0;
   logic line, pinOut, oe, pu, sysRst, wake;
   logic [4:0] q[$];
   int n_fail = 0, compares = 0, cyc = 0;
   event look;
   initial forever #12.5 clock = ~clock;
   rpc_reset_pin_control u_rpc_reset_pin_control (.clock(clock), .rst(rst), .powerOnEvent(por),
      .watchdogTimeout(wdt), .stopRecovery(rec), .brown_out_condition(bo), .stopModeActive(stp),
      .resetPinIn(line), .resetPinOut(pinOut), .resetPinOe(oe), .pullUpEnable(pu),
      .sysReset(sysRst), .stopWake(wake));
   rpc_line_model u_rpc_line_model (.resetPinOe(oe), .pullUpEnable(pu), .extLow(extLow), .line(line));
   task compare(input logic [4:0] e, input logic [4:0] a);
      compares++;
      if (a !== e) begin
         n_fail++;
         $display("[ERR] %0t exp %h got %h", $time, e, a);
      end
   endtask
   task note(input logic [4:0] e, input int n);
      repeat (n) @(negedge clock);
      q.push_back(e);
      ->look;
   endtask
   initial forever begin
      @look;
      compare(q.pop_front(), {pinOut, oe, pu, sysRst, wake});
   end
   task final_report;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 100000) begin
         n_fail++;
         final_report;
      end
   end
   initial begin
      void'($urandom(32'habf5ef25));
      repeat (12) @(posedge clock);
      @(negedge clock) rst = 0;
      note(5'h0a, 2);
      note(5'h0a, PorCycles - 2);
      note(5'h06, 1);
      note(5'h04, 10);
      {por, wdt} = 2'h1 << $urandom_range(1);
      note(5'h0a, 1);
      {por, wdt} = 2'h0;
      bo = 1;
      note(5'h06, 2);
      bo = 0;
      note(5'h0a, PorCycles - 3);
      note(5'h06, 1);
      note(5'h04, 10);
      extLow = 1;
      note(5'h06, 4 + $urandom_range(3));
      extLow = 0;
      note(5'h04, 5);
      {stp, extLow} = 2'h3;
      note(5'h04, 4);
      rec = 1;
      note(5'h07, 1);
      final_report;
   end
endmodule
